// ===== ext_trigger_pulse_timer_pkg.sv
// Constants for the external trigger pulse timer
package ext_trigger_pulse_timer_pkg;
  localparam int unsigned CNT_WIDTH = 16;
  localparam logic [15:0] COUNT_CLEAR = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [15:0] PRESCALE_DEFAULT = 16'h0001;
  localparam logic OUT_ACTIVE = 1'b1;
  localparam logic OUT_INACTIVE = 1'b0;
endpackage

// ===== ext_trigger_pulse_timer.sv
// External trigger pulse output timer, one top module
`timescale 1ns/1ps
`default_nettype none
module ext_trigger_pulse_timer #(
  parameter logic [15:0] PRESCALE = ext_trigger_pulse_timer_pkg::PRESCALE_DEFAULT
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic run_en,
  input wire logic trigger_pin,
  input wire logic [15:0] period_compare_reg,
  input wire logic [15:0] duty_compare_reg,
  output logic pulse_output_pin,
  output logic period_match_irq,
  output logic duty_match_irq,
  output logic [15:0] count_value,
  output logic full_on_impossible
);
  // Refuse a divider of zero: the prescaler end would wrap to COUNT_MAX
  if (PRESCALE == ext_trigger_pulse_timer_pkg::COUNT_CLEAR) begin : gen_bad_prescale
    $error("PRESCALE must be nonzero");
  end

  // Trigger synchroniser state
  logic trig_s1_q;
  logic trig_s1_d;
  logic trig_s2_q;
  logic trig_s2_d;
  logic trig_s3_q;
  logic trig_s3_d;

  // Count clock divider state
  logic [15:0] pre_q;
  logic [15:0] pre_d;

  // Counter state
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  // Pulse output state
  logic out_q;
  logic out_d;

  // Match interrupt state
  logic pirq_q;
  logic pirq_d;
  logic dirq_q;
  logic dirq_d;

  // Full-on status state
  logic fullno_q;
  logic fullno_d;

  // Decoded events
  logic trig_edge;
  logic tick;
  logic duty_hit;
  logic per_hit;
  logic step_ok;

  // Rising edge of the synchronised trigger
  assign trig_edge = trig_s2_q & ~trig_s3_q;
  // Last mclk of one count clock period
  assign tick = (pre_q == PRESCALE - ext_trigger_pulse_timer_pkg::COUNT_STEP);
  // Live compare values, no shadow copy
  assign duty_hit = (cnt_q == duty_compare_reg);
  assign per_hit = (cnt_q == period_compare_reg);
  // Count step that no trigger overrides
  assign step_ok = run_en & ~trig_edge & tick;

  // Trigger pin: two flops against metastability, third for the edge
  always_comb begin
    trig_s1_d = trig_s1_q;
    trig_s2_d = trig_s2_q;
    trig_s3_d = trig_s3_q;
    if (clk_en) begin
      trig_s1_d = trigger_pin;
      trig_s2_d = trig_s1_q;
      trig_s3_d = trig_s2_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= trig_s1_d;
      trig_s2_q <= trig_s2_d;
      trig_s3_q <= trig_s3_d;
    end
  end

  // Divider restarts on a trigger so the new cycle is full length
  always_comb begin
    pre_d = pre_q;
    if (clk_en) begin
      if (!run_en || trig_edge || tick) begin
        pre_d = ext_trigger_pulse_timer_pkg::COUNT_CLEAR;
      end else begin
        pre_d = pre_q + ext_trigger_pulse_timer_pkg::COUNT_STEP;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pre_q <= ext_trigger_pulse_timer_pkg::COUNT_CLEAR;
    end else begin
      pre_q <= pre_d;
    end
  end

  // Trigger clears at once, period match wraps, else count up
  always_comb begin
    cnt_d = cnt_q;
    if (clk_en) begin
      if (!run_en) begin
        cnt_d = ext_trigger_pulse_timer_pkg::COUNT_CLEAR;
      end else if (trig_edge) begin
        cnt_d = ext_trigger_pulse_timer_pkg::COUNT_CLEAR;
      end else if (tick && per_hit) begin
        cnt_d = ext_trigger_pulse_timer_pkg::COUNT_CLEAR;
      end else if (tick) begin
        cnt_d = cnt_q + ext_trigger_pulse_timer_pkg::COUNT_STEP;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_q <= ext_trigger_pulse_timer_pkg::COUNT_CLEAR;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Trigger asserts unless run_en is low; duty match wins over period match
  // Duty of period plus one never matches, so the level stays active
  always_comb begin
    out_d = out_q;
    if (clk_en) begin
      if (!run_en) begin
        out_d = ext_trigger_pulse_timer_pkg::OUT_INACTIVE;
      end else if (trig_edge) begin
        out_d = ext_trigger_pulse_timer_pkg::OUT_ACTIVE;
      end else if (tick && duty_hit) begin
        out_d = ext_trigger_pulse_timer_pkg::OUT_INACTIVE;
      end else if (tick && per_hit) begin
        out_d = ext_trigger_pulse_timer_pkg::OUT_ACTIVE;
      end
    end
  end

  // Level lands one mclk after the match edge
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      out_q <= ext_trigger_pulse_timer_pkg::OUT_INACTIVE;
    end else begin
      out_q <= out_d;
    end
  end

  // Period irq, suppressed when a trigger lands on the match
  always_comb begin
    pirq_d = pirq_q;
    if (clk_en) begin
      pirq_d = step_ok & per_hit;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pirq_q <= 1'b0;
    end else begin
      pirq_q <= pirq_d;
    end
  end

  // Duty irq on equality, not on the next increment
  always_comb begin
    dirq_d = dirq_q;
    if (clk_en) begin
      dirq_d = step_ok & duty_hit;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dirq_q <= 1'b0;
    end else begin
      dirq_q <= dirq_d;
    end
  end

  // Period at maximum leaves no room for duty of period plus one
  always_comb begin
    fullno_d = fullno_q;
    if (clk_en) begin
      fullno_d = (period_compare_reg == ext_trigger_pulse_timer_pkg::COUNT_MAX);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fullno_q <= 1'b0;
    end else begin
      fullno_q <= fullno_d;
    end
  end

  assign pulse_output_pin = out_q;
  assign period_match_irq = pirq_q;
  assign duty_match_irq = dirq_q;
  assign count_value = cnt_q;
  assign full_on_impossible = fullno_q;
endmodule
`default_nettype wire

// ===== pulse_timer_chk_sva.sv
// Port checker for the trigger pulse timer
`timescale 1ns/1ps
`default_nettype none
module pulse_timer_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic run_en,
  input wire logic pulse_output_pin,
  input wire logic period_match_irq,
  input wire logic duty_match_irq,
  input wire logic full_on_impossible,
  input wire logic [15:0] period_compare_reg,
  input wire logic [15:0] duty_compare_reg,
  input wire logic [15:0] count_value
);
  wire logic [15:0] c = count_value, d = duty_compare_reg, p = period_compare_reg;
  wire logic o = pulse_output_pin, ok = clk_en && run_en && d != p;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence rs; c == 16'h0 && o; endsequence
  AST_DM: assert property (ok && c == d |=> duty_match_irq or rs) else $error("dm");
  AST_PM: assert property (ok && c == p |=> rs) else $error("pm");
  AST_DI: assert property (duty_match_irq |-> $past(c) == $past(d)) else $error("di");
  AST_PI: assert property (period_match_irq |-> rs ##0 $past(c) == $past(p)) else $error("pi");
  AST_FO: assert property (full_on_impossible == ($past(p) == 16'hffff)) else $error("fo");
  AST_UP: assert property ($rose(o) |-> c == 16'h0) else $error("up");
  AST_DN: assert property ($fell(o) |-> duty_match_irq || !$past(run_en)) else $error("dn");
  AST_ST: assert property ($past(ok) && c != 16'h0 |-> c == $past(c) + 16'h1) else $error("st");
endmodule
bind ext_trigger_pulse_timer pulse_timer_chk chk (.*);
`default_nettype wire

// ===== trigger_source.sv
// External trigger source, holds each trigger four clocks
`timescale 1ns/1ps
`default_nettype none
module trigger_source (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic fire,
  output logic trigger_pin
);
  logic [2:0] n;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      n <= 3'h0;
    end else begin
      n <= fire ? 3'h4 : n - 3'(n != 3'h0);
    end
  end
  assign trigger_pin = n != 3'h0;
endmodule
`default_nettype wire

// ===== test_ext_trigger_pulse_timer.sv
// Random and corner stimulus for the trigger pulse timer
`timescale 1ns/1ps
`default_nettype none
module test_ext_trigger_pulse_timer;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic run_en = 1'b0;
  logic fire = 1'b0;
  logic trigger_pin;
  logic pulse_output_pin;
  logic period_match_irq;
  logic duty_match_irq;
  logic full_on_impossible;
  logic [15:0] period_compare_reg = 16'h0003;
  logic [15:0] duty_compare_reg = 16'h0001;
  logic [15:0] count_value;
  logic [15:0] p;
  logic [15:0] prev_cnt = 16'h0000;
  logic prev_out = 1'b0;
  logic [3:0] pin_hist = 4'h0;
  logic trig_seen;
  int bad_count = 0;
  int num_checks = 0;
  always #50 mclk = ~mclk;
  trigger_source src (.mclk(mclk), .nrst(nrst), .fire(fire), .trigger_pin(trigger_pin));
  ext_trigger_pulse_timer DUT (
    .mclk(mclk),
    .nrst(nrst),
    .clk_en(clk_en),
    .run_en(run_en),
    .trigger_pin(trigger_pin),
    .period_compare_reg(period_compare_reg),
    .duty_compare_reg(duty_compare_reg),
    .pulse_output_pin(pulse_output_pin),
    .period_match_irq(period_match_irq),
    .duty_match_irq(duty_match_irq),
    .count_value(count_value),
    .full_on_impossible(full_on_impossible)
  );
  // Pin as each mclk edge samples it, and the state one cycle back
  always @(negedge mclk) begin
    pin_hist <= {pin_hist[2:0], trigger_pin};
    prev_cnt <= count_value;
    prev_out <= pulse_output_pin;
  end
  function automatic logic exp_out(logic [15:0] c);
    return c <= duty_compare_reg;
  endfunction
  function automatic logic [15:0] exp_cnt(logic t, logic [15:0] c);
    return (t || c == period_compare_reg) ? 16'h0000 : c + 16'h0001;
  endfunction
  function automatic logic exp_level(logic t, logic [15:0] c, logic o);
    if (t) return 1'b1;
    if (c == duty_compare_reg) return 1'b0;
    if (c == period_compare_reg) return 1'b1;
    return o;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    bad_count += int'(seen !== exp);
    if (seen !== exp) $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #2000000;
    bad_count++;
    complete_run;
  end
  initial begin
    void'($urandom(24926));
    repeat (10) @(posedge mclk);
    nrst <= 1;
    for (int k = 0; k < 40; k++) begin
      p = k == 0 ? 16'hffff : 16'h4 + 16'($urandom % 12);
      @(posedge mclk) run_en <= 0;
      fire <= 0;
      period_compare_reg <= p;
      duty_compare_reg <= k == 1 ? p + 16'h1 : 16'h1 + 16'($urandom % (p - 16'h1));
      @(posedge mclk) run_en <= 1;
      repeat (20) @(posedge mclk);
      repeat (30) begin
        @(posedge mclk) fire <= (k > 1) && ($urandom % 6 == 0);
        @(negedge mclk);
        trig_seen = pin_hist[2] & ~pin_hist[3];
        check(full_on_impossible, p == 16'hffff);
        if (k > 0) check(pulse_output_pin, exp_out(count_value));
        check(count_value, exp_cnt(trig_seen, prev_cnt));
        check(pulse_output_pin, exp_level(trig_seen, prev_cnt, prev_out));
        check(period_match_irq, !trig_seen && prev_cnt == p);
        check(duty_match_irq, !trig_seen && prev_cnt == duty_compare_reg);
      end
    end
    complete_run;
  end
endmodule
`default_nettype wire
